// ---- inc/fsb_consts.vh ----
// register map, field positions and reset values of the signature block
// assumes a 32-bit classic wishbone slave addressed by byte
`ifndef FSB_CONSTS_VH
`define FSB_CONSTS_VH

`define FSB_OFF_ACCESS_CFG   12'h010
`define FSB_OFF_FSIG_START   12'h020
`define FSB_OFF_FSIG_STOP    12'h024
`define FSB_OFF_FSIG_WORD0   12'h02C
`define FSB_OFF_FSIG_WORD1   12'h030
`define FSB_OFF_FSIG_WORD2   12'h034
`define FSB_OFF_FSIG_WORD3   12'h038
`define FSB_OFF_EE_START     12'h09C
`define FSB_OFF_EE_STOP      12'h0A0
`define FSB_OFF_EE_SIG       12'h0A4
`define FSB_OFF_REMAP        12'h0B0
`define FSB_OFF_IRQ_ENABLE   12'h0B4
`define FSB_OFF_STATUS       12'hFE0
`define FSB_OFF_STATUS_CLR   12'hFE8

`define FSB_EE_ADDR_MSB      13
`define FSB_EE_ADDR_W        14
`define FSB_EE_SIG_W         24
`define FSB_EE_STEP          14'h0002
`define FSB_FLASH_STEP       32'h0000_0010
`define FSB_STAT_W           2
`define FSB_STAT_FLASH_DONE  0
`define FSB_STAT_EE_DONE     1

`define FSB_ACCESS_CFG_INIT  32'h0000_0000
`define FSB_ADDR_INIT        32'h0000_0000
`define FSB_EE_ADDR_INIT     14'h0000
`define FSB_IRQ_EN_INIT      2'h0
`define FSB_MODE_MSB         1
`define FSB_REMAP_BOOT       2'h0
`define FSB_REMAP_FLASH      2'h1
`define FSB_REMAP_SRAM       2'h2
`define FSB_BASE_BOOT        32'h1FFF_0000
`define FSB_BASE_FLASH       32'h0000_0000
`define FSB_BASE_SRAM        32'h1000_0000

`define FSB_MISR_POLY24      24'h80000D
`define FSB_MISR_POLY128     128'h87

`endif

// ---- logic/fsb_misr.v ----
// multiple-input signature register, one step per valid data word
// assumes data arrives on the same clock as the block using it
`timescale 1ns/1ns
`include "fsb_consts.vh"
module fsb_misr #(
    parameter              W    = 24,
    parameter [W-1:0]      POLY = 24'h80000D
) (
    input  wire            CLK,
    input  wire            clear,
    input  wire            step,
    input  wire [W-1:0]    din,
    output wire [W-1:0]    sig
);
    reg  [W-1:0] sig_reg;
    wire [W-1:0] sig_next;

    // galois shift, feedback from the top bit, xor in the data
    assign sig_next = {sig_reg[W-2:0], 1'b0}
                    ^ (sig_reg[W-1] ? POLY : {W{1'b0}}) ^ din;

    always @(posedge CLK) begin
        if (clear)
            sig_reg <= {W{1'b0}};
        else if (step)
            sig_reg <= sig_next;
    end

    assign sig = sig_reg;
endmodule

// ---- logic/fsb_top.v ----
// flash / eeprom signature and self-test register block, wishbone slave
// assumes memory read ports answer one cycle after the address is shown
`timescale 1ns/1ns
`include "fsb_consts.vh"
module fsb_top (
    input  wire         CLK,
    input  wire         RESETN,
    input  wire         WB_CYC_I,
    input  wire         WB_STB_I,
    input  wire         WB_WE_I,
    input  wire [11:0]  WB_ADR_I,
    input  wire [3:0]   WB_SEL_I,
    input  wire [31:0]  WB_DAT_I,
    output reg  [31:0]  WB_DAT_O,
    output reg          WB_ACK_O,
    output reg  [31:0]  FLASH_ADDR,
    output reg          FLASH_RD,
    input  wire [127:0] FLASH_DATA,
    output reg  [13:0]  EE_ADDR,
    output reg          EE_RD,
    input  wire [15:0]  EE_DATA,
    output reg  [31:0]  FLASH_ACCESS_CFG,
    output reg  [31:0]  VECTOR_BASE,
    output reg          IRQ
);

////////////////////////////////////////////////////////////////////////////////
// states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_READ = 2'h1;
    localparam [1:0] ST_TAKE = 2'h2;

    reg  [31:0]  fsig_start_reg;
    reg  [31:0]  fsig_stop_reg;
    reg  [13:0]  ee_start_reg;
    reg  [13:0]  ee_stop_reg;
    reg  [127:0] fsig_result_reg;
    reg  [23:0]  ee_result_reg;
    reg  [1:0]   status_reg;
    reg  [1:0]   status_next;
    reg  [1:0]   irq_en_reg;
    reg  [1:0]   remap_reg;
    reg  [1:0]   fst_reg;
    reg  [1:0]   est_reg;
    reg  [31:0]  faddr_reg;
    reg  [13:0]  eaddr_reg;
    reg          f_done_pulse;
    reg          e_done_pulse;
    reg  [31:0]  rdata;
    wire [127:0] fmisr;
    wire [23:0]  emisr;

    wire req       = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire wr        = req & WB_WE_I & (&WB_SEL_I);
    wire rd        = req & ~WB_WE_I;
    wire wr_cfg    = wr & (WB_ADR_I == `FSB_OFF_ACCESS_CFG);
    wire wr_fstart = wr & (WB_ADR_I == `FSB_OFF_FSIG_START);
    wire wr_fstop  = wr & (WB_ADR_I == `FSB_OFF_FSIG_STOP);
    wire wr_estart = wr & (WB_ADR_I == `FSB_OFF_EE_START);
    wire wr_estop  = wr & (WB_ADR_I == `FSB_OFF_EE_STOP);
    wire wr_remap  = wr & (WB_ADR_I == `FSB_OFF_REMAP);
    wire wr_irq_en = wr & (WB_ADR_I == `FSB_OFF_IRQ_ENABLE);
    wire wr_clr    = wr & (WB_ADR_I == `FSB_OFF_STATUS_CLR);
    wire f_idle    = (fst_reg == ST_IDLE);
    wire e_idle    = (est_reg == ST_IDLE);
    // a stop write mid-walk must not restart it nor wipe its signature
    wire f_start   = wr_fstop & f_idle;
    wire e_start   = wr_estop & e_idle;
    wire f_step    = (fst_reg == ST_TAKE);
    wire e_step    = (est_reg == ST_TAKE);

////////////////////////////////////////////////////////////////////////////////
// signature generators
    fsb_misr #(.W(128), .POLY(`FSB_MISR_POLY128)) u_fmisr (
        .CLK   (CLK),
        .clear (~RESETN | f_start),
        .step  (f_step),
        .din   (FLASH_DATA),
        .sig   (fmisr)
    );

    // eeprom words enter zero-extended to the signature width
    fsb_misr #(.W(`FSB_EE_SIG_W), .POLY(`FSB_MISR_POLY24)) u_emisr (
        .CLK   (CLK),
        .clear (~RESETN | e_start),
        .step  (e_step),
        .din   ({8'h00, EE_DATA}),
        .sig   (emisr)
    );

////////////////////////////////////////////////////////////////////////////////
// register writes; full-word writes only, partial writes ignored
    always @(posedge CLK) begin
        if (!RESETN)
            FLASH_ACCESS_CFG <= `FSB_ACCESS_CFG_INIT;
        else if (wr_cfg)
            FLASH_ACCESS_CFG <= WB_DAT_I;
    end

    always @(posedge CLK) begin
        if (!RESETN) begin
            fsig_start_reg <= `FSB_ADDR_INIT;
            fsig_stop_reg  <= `FSB_ADDR_INIT;
        end else begin
            if (wr_fstart)
                fsig_start_reg <= WB_DAT_I;
            if (wr_fstop)
                fsig_stop_reg  <= WB_DAT_I;
        end
    end

    // bit 0 always cleared: the self test only reads 16-bit words
    always @(posedge CLK) begin
        if (!RESETN) begin
            ee_start_reg <= `FSB_EE_ADDR_INIT;
            ee_stop_reg  <= `FSB_EE_ADDR_INIT;
        end else begin
            if (wr_estart)
                ee_start_reg <= {WB_DAT_I[`FSB_EE_ADDR_MSB:1], 1'b0};
            if (wr_estop)
                ee_stop_reg  <= {WB_DAT_I[`FSB_EE_ADDR_MSB:1], 1'b0};
        end
    end

    always @(posedge CLK) begin
        if (!RESETN) begin
            remap_reg  <= `FSB_REMAP_BOOT;
            irq_en_reg <= `FSB_IRQ_EN_INIT;
        end else begin
            if (wr_remap)
                remap_reg  <= WB_DAT_I[`FSB_MODE_MSB:0];
            if (wr_irq_en)
                irq_en_reg <= WB_DAT_I[`FSB_STAT_W-1:0];
        end
    end

////////////////////////////////////////////////////////////////////////////////
// flash signature walk, one 128-bit line per read
    always @(posedge CLK) begin
        if (!RESETN) begin
            fst_reg      <= ST_IDLE;
            faddr_reg    <= 32'h0000_0000;
            FLASH_ADDR   <= 32'h0000_0000;
            FLASH_RD     <= 1'b0;
            f_done_pulse <= 1'b0;
        end else begin
            f_done_pulse <= 1'b0;
            FLASH_RD     <= 1'b0;
            case (fst_reg)
            ST_IDLE: begin
                if (f_start) begin
                    faddr_reg <= fsig_start_reg;
                    fst_reg   <= ST_READ;
                end
            end
            ST_READ: begin
                FLASH_ADDR <= faddr_reg;
                FLASH_RD   <= 1'b1;
                fst_reg    <= ST_TAKE;
            end
            ST_TAKE: begin
                // stop address is inclusive; a stop below start reads once
                if (faddr_reg >= fsig_stop_reg) begin
                    fst_reg      <= ST_IDLE;
                    f_done_pulse <= 1'b1;
                end else begin
                    faddr_reg <= faddr_reg + `FSB_FLASH_STEP;
                    fst_reg   <= ST_READ;
                end
            end
            default: fst_reg <= ST_IDLE;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
// eeprom self test walk, 16-bit reads at even addresses
    always @(posedge CLK) begin
        if (!RESETN) begin
            est_reg      <= ST_IDLE;
            eaddr_reg    <= 14'h0000;
            EE_ADDR      <= 14'h0000;
            EE_RD        <= 1'b0;
            e_done_pulse <= 1'b0;
        end else begin
            e_done_pulse <= 1'b0;
            EE_RD        <= 1'b0;
            case (est_reg)
            ST_IDLE: begin
                // start register already programmed before this write
                if (e_start) begin
                    eaddr_reg <= ee_start_reg;
                    est_reg   <= ST_READ;
                end
            end
            ST_READ: begin
                EE_ADDR <= {eaddr_reg[`FSB_EE_ADDR_MSB:1], 1'b0};
                EE_RD   <= 1'b1;
                est_reg <= ST_TAKE;
            end
            ST_TAKE: begin
                // stop address is inclusive, as for the flash walk
                if (eaddr_reg >= ee_stop_reg) begin
                    est_reg      <= ST_IDLE;
                    e_done_pulse <= 1'b1;
                end else begin
                    eaddr_reg <= eaddr_reg + `FSB_EE_STEP;
                    est_reg   <= ST_READ;
                end
            end
            default: est_reg <= ST_IDLE;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
// results and sticky status; a set in the clearing cycle wins
    always @* begin
        status_next = status_reg;
        if (wr_clr)
            status_next = status_reg & ~WB_DAT_I[`FSB_STAT_W-1:0];
        if (f_done_pulse)
            status_next[`FSB_STAT_FLASH_DONE] = 1'b1;
        if (e_done_pulse)
            status_next[`FSB_STAT_EE_DONE] = 1'b1;
    end

    always @(posedge CLK) begin
        if (!RESETN) begin
            status_reg      <= 2'h0;
            fsig_result_reg <= 128'h0;
            ee_result_reg   <= 24'h000000;
            IRQ             <= 1'b0;
        end else begin
            status_reg <= status_next;
            // from the next status so irq rises with its flag
            IRQ        <= |(status_next & irq_en_reg);
            if (f_done_pulse)
                fsig_result_reg <= fmisr;
            if (e_done_pulse)
                ee_result_reg <= emisr;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// vector region base follows the mapping mode
    always @(posedge CLK) begin
        if (!RESETN)
            VECTOR_BASE <= `FSB_BASE_BOOT;
        else begin
            case (remap_reg)
            `FSB_REMAP_FLASH: VECTOR_BASE <= `FSB_BASE_FLASH;
            `FSB_REMAP_SRAM:  VECTOR_BASE <= `FSB_BASE_SRAM;
            // mode 3 is unused and falls back to the boot rom
            default:          VECTOR_BASE <= `FSB_BASE_BOOT;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
// read mux and ack; unmapped and write-only offsets read zero
    always @* begin
        rdata = 32'h0000_0000;
        case (WB_ADR_I)
        `FSB_OFF_ACCESS_CFG: rdata = FLASH_ACCESS_CFG;
        `FSB_OFF_FSIG_START: rdata = fsig_start_reg;
        `FSB_OFF_FSIG_STOP:  rdata = fsig_stop_reg;
        `FSB_OFF_FSIG_WORD0: rdata = fsig_result_reg[31:0];
        `FSB_OFF_FSIG_WORD1: rdata = fsig_result_reg[63:32];
        `FSB_OFF_FSIG_WORD2: rdata = fsig_result_reg[95:64];
        `FSB_OFF_FSIG_WORD3: rdata = fsig_result_reg[127:96];
        `FSB_OFF_EE_START:   rdata = {18'h00000, ee_start_reg};
        `FSB_OFF_EE_STOP:    rdata = {18'h00000, ee_stop_reg};
        `FSB_OFF_EE_SIG:     rdata = {8'h00, ee_result_reg};
        `FSB_OFF_REMAP:      rdata = {30'h00000000, remap_reg};
        `FSB_OFF_IRQ_ENABLE: rdata = {30'h00000000, irq_en_reg};
        `FSB_OFF_STATUS:     rdata = {30'h00000000, status_reg};
        default:             rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge CLK) begin
        if (!RESETN) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            // every access acks, even unmapped ones, so the bus never hangs
            WB_ACK_O <= req;
            WB_DAT_O <= rd ? rdata : 32'h0000_0000;
        end
    end
endmodule

// ---- verif/fsb_top_assertions.sv ----
// checker of the signature block: bus answer, self-test strobes, remap
// assumes binding onto fsb_top, one clock, synchronous active-low reset
`timescale 1ns/1ns
`include "fsb_consts.vh"
module fsb_chk (
    input wire        CLK,
    input wire        RESETN,
    input wire        WB_CYC_I,
    input wire        WB_STB_I,
    input wire        WB_WE_I,
    input wire [11:0] WB_ADR_I,
    input wire [3:0]  WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    input wire [31:0] WB_DAT_O,
    input wire        WB_ACK_O,
    input wire        FLASH_RD,
    input wire [13:0] EE_ADDR,
    input wire        EE_RD,
    input wire [31:0] VECTOR_BASE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    wire tk = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire wr = tk && WB_WE_I && (WB_SEL_I == 4'hF);
    function [31:0] base(input [31:0] m);
        base = (m[1:0] == `FSB_REMAP_FLASH) ? `FSB_BASE_FLASH :
               (m[1:0] == `FSB_REMAP_SRAM) ? `FSB_BASE_SRAM : `FSB_BASE_BOOT;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    bus_answer_a: assert property (tk |=> WB_ACK_O)
        else $error("request not answered next cycle");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    idle_data_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data outside ack");
    clear_reads_a: assert property (tk && !WB_WE_I &&
        WB_ADR_I == `FSB_OFF_STATUS_CLR |=> WB_DAT_O == 32'h0)
        else $error("clear register read nonzero");
    ee_even_a: assert property (EE_RD |-> !EE_ADDR[0] ##1 !EE_RD)
        else $error("odd or stretched eeprom read");
    ee_launch_a: assert property (wr &&
        WB_ADR_I == `FSB_OFF_EE_STOP |-> ##2 EE_RD)
        else $error("stop write did not launch self test");
    flash_launch_a: assert property (wr &&
        WB_ADR_I == `FSB_OFF_FSIG_STOP |-> ##2 FLASH_RD)
        else $error("stop write did not launch flash walk");
    vector_map_a: assert property (wr && WB_ADR_I == `FSB_OFF_REMAP
        |-> ##2 VECTOR_BASE == base($past(WB_DAT_I, 2)))
        else $error("vector base not per mode");
    cover property (EE_RD ##2 EE_RD);
    cover property (FLASH_RD);
    cover property (wr && WB_ADR_I == `FSB_OFF_STATUS_CLR);
endmodule
bind fsb_top fsb_chk u_chk (
    .CLK(CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .FLASH_RD(FLASH_RD), .EE_ADDR(EE_ADDR), .EE_RD(EE_RD),
    .VECTOR_BASE(VECTOR_BASE)
);

// ---- verif/flash_eeprom_signature_bist_bench.sv ----
// self-checking bench: registers, self-test walks, status, irq, remap
// assumes fsb_top answers each bus request one cycle after it is taken
`timescale 1ns/1ns
`include "fsb_consts.vh"
module flash_eeprom_signature_bist_bench;
    reg          clk, resetn, cyc, stb, we;
    reg  [11:0]  adr;
    reg  [3:0]   sel;
    reg  [31:0]  wdat, seed, q, r, mr, f_next;
    reg  [127:0] f_data, f_exp;
    reg  [15:0]  e_data;
    reg  [23:0]  e_exp;
    reg  [13:0]  e_next, s;
    wire [31:0]  rdat, f_addr, acfg, vbase;
    wire [13:0]  e_addr;
    wire         ack, f_rd, e_rd, irq;
    integer      n_fail, check_count, k;
    localparam [11:0] ZO [9] = '{`FSB_OFF_ACCESS_CFG, `FSB_OFF_FSIG_START,
        `FSB_OFF_FSIG_STOP, `FSB_OFF_EE_START, `FSB_OFF_EE_STOP,
        `FSB_OFF_EE_SIG, `FSB_OFF_STATUS, `FSB_OFF_STATUS_CLR, 12'h400};
    localparam [11:0] RW [3] = '{`FSB_OFF_EE_START, `FSB_OFF_FSIG_START,
        `FSB_OFF_ACCESS_CFG};
    fsb_top dut (.CLK(clk), .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .FLASH_ADDR(f_addr), .FLASH_RD(f_rd),
        .FLASH_DATA(f_data), .EE_ADDR(e_addr), .EE_RD(e_rd),
        .EE_DATA(e_data), .FLASH_ACCESS_CFG(acfg), .VECTOR_BASE(vbase),
        .IRQ(irq));
    ////////////////////////////////////////////////////////////////////////
    function automatic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function [23:0] m24(input [23:0] a, input [23:0] d);
        return {a[22:0], 1'b0} ^ (a[23] ? `FSB_MISR_POLY24 : 24'h0) ^ d;
    endfunction
    function [127:0] m128(input [127:0] a, input [127:0] d);
        return {a[126:0], 1'b0} ^ (a[127] ? `FSB_MISR_POLY128 : 128'h0) ^ d;
    endfunction
    task automatic chk(input [127:0] seen, input [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // called just after a rising edge; returns just after one
    task wb(input [11:0] a, input w, input [31:0] d, input [3:0] b);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, b};
        do @(posedge clk);
        while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    task wait_done(input integer bit_no);
        do wb(`FSB_OFF_STATUS, 0, 0, 4'hF);
        while (q[bit_no] !== 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    // memories answer with fresh random data every cycle
    always @(posedge clk) begin
        if (e_rd === 1'b1) begin
            chk(e_addr, e_next);
            e_exp = m24(e_exp, {8'h00, e_data});
            e_next = e_next + 14'h0002;
        end
        if (f_rd === 1'b1) begin
            chk(f_addr, f_next);
            f_exp = m128(f_exp, f_data);
            f_next = f_next + `FSB_FLASH_STEP;
        end
        mr = rnd();
        e_data <= mr[15:0];
        f_data <= {rnd(), rnd(), rnd(), rnd()};
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize;
    end
    initial begin
        seed = 32'h0000DF62;
        {cyc, stb, we, adr, wdat, sel} = 0;
        {resetn, e_data, f_data, e_exp, f_exp, e_next, f_next} = 0;
        n_fail = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk({irq, vbase}, {1'b0, `FSB_BASE_BOOT});
        for (k = 0; k < 9; k++) begin
            wb(ZO[k], 0, 0, 4'hF);
            chk(q, 0);
        end
        for (k = 0; k < 3; k++) begin
            r = rnd();
            wb(RW[k], 1, r, 4'hF);
            wb(RW[k], 0, 0, 4'hF);
            chk(q, k == 0 ? {18'h0, r[13:1], 1'b0} : r);
        end
        wb(`FSB_OFF_ACCESS_CFG, 1, ~r, 4'h3);
        chk(acfg, r);
        wb(`FSB_OFF_IRQ_ENABLE, 1, 3, 4'hF);
        for (k = 0; k < 3; k++) begin
            r = rnd();
            s = {1'b0, r[12:1], 1'b0};
            {e_next, e_exp} = {s, 24'h0};
            wb(`FSB_OFF_EE_START, 1, {19'h0, r[12:0]}, 4'hF);
            wb(`FSB_OFF_EE_STOP, 1, s + 2 * k, 4'hF);
            wait_done(1);
            chk({irq, q}, {k != 2, 32'h2});
            chk(e_next, s + 2 * (k + 1));
            wb(`FSB_OFF_EE_SIG, 1, 32'hFFFFFFFF, 4'hF);
            wb(`FSB_OFF_EE_SIG, 0, 0, 4'hF);
            chk(q, {8'h00, e_exp});
            wb(`FSB_OFF_IRQ_ENABLE, 1, k == 1 ? 1 : 3, 4'hF);
            @(posedge clk);
            chk(irq, k != 1);
            wb(`FSB_OFF_STATUS_CLR, 1, 3, 4'hF);
            wb(`FSB_OFF_STATUS, 0, 0, 4'hF);
            chk({irq, q}, 33'h0);
        end
        r = rnd();
        {f_next, f_exp} = {20'h0, r[11:4], 4'h0, 128'h0};
        wb(`FSB_OFF_FSIG_START, 1, f_next, 4'hF);
        wb(`FSB_OFF_FSIG_STOP, 1, f_next + 32'h20, 4'hF);
        wait_done(0);
        wb(`FSB_OFF_FSIG_WORD0, 1, ~r, 4'hF);
        for (k = 0; k < 4; k++) begin
            wb(`FSB_OFF_FSIG_WORD0 + 12'h4 * k[11:0], 0, 0, 4'hF);
            chk(q, f_exp[32 * k +: 32]);
        end
        wb(`FSB_OFF_STATUS, 0, 0, 4'hF);
        chk(q, 1);
        for (k = 0; k < 4; k++) begin
            wb(`FSB_OFF_REMAP, 1, k, 4'hF);
            @(posedge clk);
            chk(vbase, k == 1 ? `FSB_BASE_FLASH :
                k == 2 ? `FSB_BASE_SRAM : `FSB_BASE_BOOT);
        end
        summarize;
    end
endmodule
